// file: logic/cfg_msg_access.sv
`include "cfg_msg_map.svh"

module cfg_msg_access
   import cfg_msg_pkg::*;
#(
   parameter int MAX_PSIZE = 8
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Incoming request tokens
   input wire logic in_valid,
   input wire in_tok_t in_tok,
   output logic in_ready,
   // Outgoing reply tokens
   output logic out_valid,
   output out_tok_t out_tok,
   input wire logic out_ready,
   // Register bank access
   output reg_cmd_t reg_cmd,
   input wire logic reg_ack,
   input wire logic reg_ok,
   input wire logic [31:0] reg_rdata,
   // Local processor-status access
   input wire logic ps_req,
   input wire logic ps_write,
   input wire logic [31:0] ps_resid,
   input wire logic [31:0] ps_wdata,
   output ps_cmd_t ps_cmd
);

   localparam int PW = (MAX_PSIZE > 4) ? $clog2(MAX_PSIZE) : 2;
   localparam int DEPTH = (MAX_PSIZE > 4) ? MAX_PSIZE : 4;

   typedef enum logic [1:0] {
      ST_COLLECT,
      ST_ACCESS,
      ST_REPLY
   } state_t;

   // ****************************************
   // Helpers
   // ****************************************

   // Register number from a processor-status resource identifier
   function automatic logic [23:0] ps_number(input logic [31:0] resid);
      ps_number = resid[31:`PS_SHIFT];
   endfunction

   // ****************************************
   // State
   // ****************************************

   state_t state_ff, nxt_state;
   logic have_op_ff;
   logic [7:0] op_ff;
   bank_t bank_ff;
   logic [3:0] cnt_ff;
   logic [71:0] buf_ff;
   logic [23:0] id_ff;
   logic fail_ff;
   logic [7:0] size_ff;
   logic [7:0] k_ff;
   logic [7:0] idx_ff;
   logic [7:0] pbuf [DEPTH];
   logic out_valid_ff;
   out_tok_t out_tok_ff;
   reg_cmd_t reg_cmd_ff;
   ps_cmd_t ps_cmd_ff;

   // ****************************************
   // Message decode
   // ****************************************

   // Token handshake and message framing
   wire take = in_valid && in_ready;
   wire tok_end = take && in_tok.ctrl && (in_tok.data == `TOK_END);
   wire tok_op = take && in_tok.ctrl && (in_tok.data != `TOK_END);
   wire tok_byte = take && !in_tok.ctrl && have_op_ff;

   // Fields, most significant byte first
   wire [15:0] w_reg = buf_ff[47:32];
   wire [31:0] w_data = buf_ff[31:0];
   wire [15:0] r_reg = buf_ff[15:0];
   wire [7:0] p_reg = buf_ff[15:8];
   wire [7:0] p_size = buf_ff[7:0];

   // Legal forms of each message per bank
   wire is_cfg = (bank_ff != BANK_PERIPH);
   wire good_wr = (op_ff == `TOK_OP_WRITE) && is_cfg && (cnt_ff == `LEN_CFG_WRITE);
   wire good_rd = (op_ff == `TOK_OP_READ) && is_cfg && (cnt_ff == `LEN_CFG_READ);
   wire good_pr = (op_ff == `TOK_OP_PREAD) && (bank_ff == BANK_PERIPH)
      && (cnt_ff == `LEN_PREAD) && (p_size != 8'h00)
      && (p_size <= 8'(MAX_PSIZE));
   wire good_msg = good_wr || good_rd || good_pr;
   wire has_id = (cnt_ff >= `LEN_ID);
   wire suppress = (op_ff == `TOK_OP_WRITE) && (id_ff[7:0] == `NOREPLY_LOW);

   // Bank access completion
   wire acc_done = (state_ff == ST_ACCESS) && reg_ack && reg_cmd_ff.req;
   wire acc_more = reg_cmd_ff.bank == BANK_PERIPH && (k_ff + 8'h01 < size_ff);

   // Reply sequence
   wire [7:0] nbytes = reg_cmd_ff.write ? 8'h00 : size_ff;
   wire [7:0] last_idx = fail_ff ? 8'h01 : nbytes + 8'h01;
   wire out_free = !out_valid_ff || out_ready;
   wire emit = (state_ff == ST_REPLY) && out_free;
   wire [7:0] didx = idx_ff - 8'h01;
   wire [7:0] pdata = pbuf[didx[PW-1:0]];

   // Next reply token
   logic nxt_ctrl;
   logic [7:0] nxt_data;
   always_comb begin
      nxt_ctrl = 1'b1;
      nxt_data = `TOK_END;
      if (idx_ff == 8'h00) begin
         nxt_data = fail_ff ? `TOK_NAK : `TOK_ACK;
      end else if (idx_ff != last_idx) begin
         nxt_ctrl = 1'b0;
         nxt_data = pdata;
      end
   end

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_COLLECT: begin
            if (tok_end && have_op_ff) begin
               if (good_msg) begin
                  nxt_state = ST_ACCESS;
               end else if (has_id && !suppress) begin
                  nxt_state = ST_REPLY;
               end
            end
         end
         ST_ACCESS: begin
            if (acc_done && (!reg_ok || !acc_more)) begin
               nxt_state = (reg_cmd_ff.write && suppress) ? ST_COLLECT : ST_REPLY;
            end
         end
         ST_REPLY: begin
            if (emit && idx_ff == last_idx) begin
               nxt_state = ST_COLLECT;
            end
         end
         default: nxt_state = ST_COLLECT;
      endcase
   end

   assign in_ready = (state_ff == ST_COLLECT);

   // ****************************************
   // Registers
   // ****************************************

   // Framing state and byte collection
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_ff <= ST_COLLECT;
         have_op_ff <= 1'b0;
         op_ff <= 8'h0000;
         bank_ff <= BANK_TILE;
         cnt_ff <= 4'h0;
         buf_ff <= '0;
         id_ff <= 24'h00_0000;
      end else if (ce) begin
         state_ff <= nxt_state;
         if (tok_op) begin
            have_op_ff <= 1'b1;
            op_ff <= in_tok.data;
            bank_ff <= in_tok.bank;
            cnt_ff <= 4'h0;
            buf_ff <= '0;
         end else if (tok_end) begin
            have_op_ff <= 1'b0;
         end else if (tok_byte) begin
            buf_ff <= {buf_ff[63:0], in_tok.data};
            if (cnt_ff != 4'hF) begin
               cnt_ff <= cnt_ff + 4'h1;
            end
            if (cnt_ff < `LEN_ID) begin
               id_ff <= {id_ff[15:0], in_tok.data};
            end
         end
      end
   end

   // Bank access sequencing
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_cmd_ff <= '0;
         fail_ff <= 1'b0;
         size_ff <= 8'h0000;
         k_ff <= 8'h0000;
      end else if (ce) begin
         if (state_ff == ST_COLLECT && tok_end && have_op_ff) begin
            fail_ff <= !good_msg;
            reg_cmd_ff.req <= good_msg;
            reg_cmd_ff.write <= good_wr;
            reg_cmd_ff.bank <= bank_ff;
            reg_cmd_ff.addr <= good_wr ? w_reg : (good_rd ? r_reg : {8'h00, p_reg});
            reg_cmd_ff.wdata <= good_wr ? w_data : 32'h0000_0000;
            size_ff <= good_pr ? p_size : 8'h0004;
            k_ff <= 8'h0000;
         end else if (acc_done) begin
            if (!reg_ok || !acc_more) begin
               reg_cmd_ff.req <= 1'b0;
               fail_ff <= !reg_ok;
            end else begin
               k_ff <= k_ff + 8'h01;
               reg_cmd_ff.addr <= reg_cmd_ff.addr + 16'h0001;
            end
         end
      end
   end

   // Read data capture: config word split most significant byte first, peripheral low byte per access
   always_ff @(posedge clk) begin
      if (acc_done && reg_ok && ce) begin
         if (reg_cmd_ff.bank == BANK_PERIPH) begin
            pbuf[k_ff[PW-1:0]] <= reg_rdata[7:0];
         end else begin
            for (int i = 0; i < 4; i++) begin
               pbuf[i] <= reg_rdata[31-8*i -: 8];
            end
         end
      end
   end

   // Reply emission
   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_valid_ff <= 1'b0;
         out_tok_ff <= '0;
         idx_ff <= 8'h0000;
      end else if (ce) begin
         if (emit) begin
            out_valid_ff <= 1'b1;
            out_tok_ff <= '{dest: id_ff, ctrl: nxt_ctrl, data: nxt_data};
            idx_ff <= (idx_ff == last_idx) ? 8'h0000 : idx_ff + 8'h01;
         end else if (out_ready) begin
            out_valid_ff <= 1'b0;
         end
      end
   end

   // Local processor-status command, one full word
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ps_cmd_ff <= '0;
      end else if (ce) begin
         ps_cmd_ff.valid <= ps_req;
         if (ps_req) begin
            ps_cmd_ff.write <= ps_write;
            ps_cmd_ff.bad_id <= (ps_resid[7:0] != `PS_SUFFIX);
            ps_cmd_ff.num <= ps_number(ps_resid);
            ps_cmd_ff.wdata <= ps_wdata;
         end
      end
   end

   assign out_valid = out_valid_ff;
   assign out_tok = out_tok_ff;
   assign reg_cmd = reg_cmd_ff;
   assign ps_cmd = ps_cmd_ff;

endmodule // cfg_msg_access

// file: logic/cfg_msg_map.svh
`ifndef CFG_MSG_MAP_SVH
`define CFG_MSG_MAP_SVH

// Control token codes
`define TOK_OP_WRITE 8'h00C0
`define TOK_OP_READ 8'h00C1
`define TOK_OP_PREAD 8'h0025
`define TOK_END 8'h0001
`define TOK_ACK 8'h0003
`define TOK_NAK 8'h0004

// Reply identifier low byte that suppresses a write reply
`define NOREPLY_LOW 8'h00FF

// Processor-status resource identifier layout
`define PS_SUFFIX 8'h000C
`define PS_SHIFT 8

// Payload byte counts between opcode and end token
`define LEN_CFG_WRITE 4'h9
`define LEN_CFG_READ 4'h5
`define LEN_PREAD 4'h5
`define LEN_ID 4'h3

`endif

// file: logic/cfg_msg_pkg.sv
package cfg_msg_pkg;

   // Bank that the interconnect routed the message to
   typedef enum logic [1:0] {
      BANK_TILE,
      BANK_NODE,
      BANK_PERIPH
   } bank_t;

   // One incoming interconnect token with its destination bank
   typedef struct packed {
      bank_t bank;
      logic ctrl;
      logic [7:0] data;
   } in_tok_t;

   // One outgoing reply token with its reply channel-end
   typedef struct packed {
      logic [23:0] dest;
      logic ctrl;
      logic [7:0] data;
   } out_tok_t;

   // Register access command toward the banks
   typedef struct packed {
      logic req;
      logic write;
      bank_t bank;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_cmd_t;

   // Local processor-status access command
   typedef struct packed {
      logic valid;
      logic write;
      logic bad_id;
      logic [23:0] num;
      logic [31:0] wdata;
   } ps_cmd_t;

endpackage

// file: tb/cfg_msg_access_checker.sv
module cfg_msg_access_checker
   import cfg_msg_pkg::*;
(
   // Clock and control
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Token and reply sides
   input wire logic in_ready,
   input wire logic out_valid,
   input wire out_tok_t out_tok,
   input wire logic out_ready,
   // Bank and status sides
   input wire reg_cmd_t reg_cmd,
   input wire logic reg_ack,
   input wire logic ps_req,
   input wire logic ps_write,
   input wire logic [31:0] ps_resid,
   input wire logic [31:0] ps_wdata,
   input wire ps_cmd_t ps_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Port checks
   // ****
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_ps_pulse: assert property (ps_req && ce |=> ps_cmd.valid)
      else $error("status command missing");
   a_ps_idle: assert property (!ps_req && ce |=> !ps_cmd.valid)
      else $error("status command unasked");
   a_ps_num: assert property (ps_req && ce |=> ps_cmd.num == $past(ps_resid[31:8]))
      else $error("status number wrong");
   a_ps_bad: assert property (ps_req && ce |=>
      ps_cmd.bad_id == ($past(ps_resid[7:0]) != 8'h0C)) else $error("status suffix wrong");
   a_ps_word: assert property (ps_req && ce |=> ps_cmd.wdata == $past(ps_wdata)
      && ps_cmd.write == $past(ps_write)) else $error("status word wrong");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_tok))
      else $error("reply token dropped");
   a_req_hold: assert property (reg_cmd.req && !reg_ack |=> reg_cmd.req && $stable(reg_cmd))
      else $error("bank access dropped");
   a_busy_stop: assert property (out_valid && !(out_tok.ctrl && out_tok.data == 8'h01)
      |-> !in_ready) else $error("tokens taken while replying");
   a_reply_open: assert property ($rose(out_valid) |->
      out_tok.ctrl && out_tok.data inside {8'h03, 8'h04}) else $error("bad reply start");
   a_nak_end: assert property (ce && out_valid && out_ready && out_tok.ctrl
      && out_tok.data == 8'h04 |=> !out_valid || (out_tok.ctrl && out_tok.data == 8'h01))
      else $error("failure not closed");
endmodule // cfg_msg_access_checker

// file: tb/cfg_bank_model.sv
module cfg_bank_model
   import cfg_msg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Bank access
   input wire reg_cmd_t reg_cmd,
   output logic reg_ack,
   output logic reg_ok,
   output logic [31:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem_ff [16];
   logic [1:0] wait_ff;
   // Only sixteen registers exist; others fail
   assign reg_ok = reg_cmd.addr < 16'h0010;
   assign reg_rdata = reg_ack ? mem_ff[reg_cmd.addr[3:0]] : ~mem_ff[reg_cmd.addr[3:0]];
   // Odd addresses answer slowly
   initial for (int i = 0; i < 16; i++) mem_ff[i] = {4{i[7:0]}};
   always @(posedge clk) begin
      reg_ack <= 1'b0;
      if (!nrst) begin
         wait_ff <= 2'h0;
      end else if (reg_cmd.req && !reg_ack) begin
         wait_ff <= wait_ff + 2'h1;
         if (wait_ff == {reg_cmd.addr[0], 1'b0}) begin
            reg_ack <= 1'b1;
            wait_ff <= 2'h0;
            if (reg_cmd.write && reg_ok) mem_ff[reg_cmd.addr[3:0]] <= reg_cmd.wdata;
         end
      end
   end
endmodule // cfg_bank_model

// file: tb/config_register_message_access_bench.sv
module config_register_message_access_bench
   import cfg_msg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, ce, in_valid, in_ready, out_valid, out_ready, reg_ack, reg_ok;
   logic ps_req, ps_write;
   logic [31:0] reg_rdata, ps_resid, ps_wdata;
   in_tok_t in_tok;
   out_tok_t out_tok;
   reg_cmd_t reg_cmd;
   ps_cmd_t ps_cmd;
   int checks, num_errors, cyc;
   // ****
   // Design and bank
   // ****
   cfg_msg_access DUT (.clk(clk), .nrst(nrst), .ce(ce), .in_valid(in_valid),
      .in_tok(in_tok), .in_ready(in_ready), .out_valid(out_valid), .out_tok(out_tok),
      .out_ready(out_ready), .reg_cmd(reg_cmd), .reg_ack(reg_ack), .reg_ok(reg_ok),
      .reg_rdata(reg_rdata), .ps_req(ps_req), .ps_write(ps_write), .ps_resid(ps_resid),
      .ps_wdata(ps_wdata), .ps_cmd(ps_cmd));
   cfg_bank_model bank (.clk(clk), .nrst(nrst), .reg_cmd(reg_cmd), .reg_ack(reg_ack),
      .reg_ok(reg_ok), .reg_rdata(reg_rdata));
   // Clock and hang limit
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic put(input bank_t bk, input logic c, input logic [7:0] d);
      in_valid = 1'b1;
      in_tok = {bk, c, d};
      for (int w = 0; w < 100 && !in_ready; w++) @(negedge clk);
      @(negedge clk);
   endtask
   // Opcode, payload bytes high first, end token
   task automatic send(input logic [7:0] op, input bank_t bk, input logic [71:0] p, input int n);
      put(bk, 1'b1, op);
      for (int i = 0; i < n; i++) put(bk, 1'b0, p[8*(n-i)-1 -: 8]);
      put(bk, 1'b1, 8'h01);
      in_valid = 1'b0;
   endtask
   // Collect reply with the sink stalling every other cycle
   task automatic reply(input logic [23:0] id, input logic [53:0] ex, input int n);
      int k;
      k = 0;
      for (int c = 0; c < 60; c++) begin
         @(negedge clk);
         out_ready = c[0];
         if (out_valid && out_ready) begin
            chk({out_tok.dest, out_tok.ctrl, out_tok.data}, {id, ex[53-9*k -: 9]});
            k++;
         end
      end
      chk(33'(k), 33'(n));
   endtask
   task automatic t_cfg;
      send(8'hC0, BANK_TILE, {24'h12_3456, 16'h0005, 32'hA1B2_C3D4}, 9);
      reply(24'h12_3456, {9'h103, 9'h101, 36'h0}, 2);
      send(8'hC1, BANK_TILE, {24'h12_3456, 16'h0005}, 5);
      reply(24'h12_3456, {9'h103, 9'h0A1, 9'h0B2, 9'h0C3, 9'h0D4, 9'h101}, 6);
      send(8'hC0, BANK_NODE, {24'h12_34FF, 16'h0002, 32'h0000_5A5A}, 9);
      reply(24'h12_34FF, 54'h0, 0);
      send(8'hC1, BANK_NODE, {24'h65_4321, 16'h0002}, 5);
      reply(24'h65_4321, {9'h103, 9'h000, 9'h000, 9'h05A, 9'h05A, 9'h101}, 6);
      $display("test cfg done");
   endtask
   task automatic t_fail;
      send(8'hC0, BANK_TILE, {24'h00_0A01, 16'h0100, 32'h0000_0001}, 9);
      reply(24'h00_0A01, {9'h104, 9'h101, 36'h0}, 2);
      send(8'hC1, BANK_TILE, {24'h00_0A02, 16'h0005, 8'h00}, 6);
      reply(24'h00_0A02, {9'h104, 9'h101, 36'h0}, 2);
      send(8'h25, BANK_TILE, {24'h00_0A03, 8'h03, 8'h01}, 5);
      reply(24'h00_0A03, {9'h104, 9'h101, 36'h0}, 2);
      $display("test fail done");
   endtask
   task automatic t_pread;
      send(8'h25, BANK_PERIPH, {24'h00_0B01, 8'h03, 8'h02}, 5);
      reply(24'h00_0B01, {9'h103, 9'h003, 9'h004, 9'h101, 18'h0}, 4);
      send(8'h25, BANK_PERIPH, {24'h00_0B02, 8'h03, 8'h00}, 5);
      reply(24'h00_0B02, {9'h104, 9'h101, 36'h0}, 2);
      send(8'h25, BANK_PERIPH, {24'h00_0B03, 8'h03, 8'h09}, 5);
      reply(24'h00_0B03, {9'h104, 9'h101, 36'h0}, 2);
      $display("test pread done");
   endtask
   task automatic t_ps;
      for (int i = 0; i < 2; i++) begin
         ps_req = 1'b1;
         ps_write = i[0];
         ps_resid = {24'h00_0005 + 24'(i), 8'h0C + 8'(i)};
         ps_wdata = 32'hCAFE_F00D;
         @(negedge clk);
         chk({ps_cmd.valid, ps_cmd.write, ps_cmd.bad_id, ps_cmd.num},
            {1'b1, i[0], i[0], 24'h00_0005 + 24'(i)});
         chk(ps_cmd.wdata, 32'hCAFE_F00D);
      end
      // Enable low freezes the status command
      ce = 1'b0;
      ps_resid = {24'h00_0077, 8'h0C};
      @(negedge clk);
      chk({ps_cmd.valid, ps_cmd.num}, {1'b1, 24'h00_0006});
      ce = 1'b1;
      ps_req = 1'b0;
      @(negedge clk);
      chk(ps_cmd.valid, 1'b0);
      $display("test status done");
   endtask
   task automatic end_sim;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Reset, then the scenarios
   initial begin
      {clk, nrst, in_valid, out_ready, ps_req, ps_write} = '0;
      ce = 1'b1;
      in_tok = '0;
      {ps_resid, ps_wdata} = '0;
      repeat (5) @(negedge clk);
      nrst = 1'b1;
      t_cfg();
      t_fail();
      t_pread();
      t_ps();
      end_sim();
   end
endmodule // config_register_message_access_bench
bind cfg_msg_access cfg_msg_access_checker chk_i (.clk(clk), .nrst(nrst), .ce(ce),
   .in_ready(in_ready), .out_valid(out_valid), .out_tok(out_tok), .out_ready(out_ready),
   .reg_cmd(reg_cmd), .reg_ack(reg_ack), .ps_req(ps_req), .ps_write(ps_write),
   .ps_resid(ps_resid), .ps_wdata(ps_wdata), .ps_cmd(ps_cmd));
